// *** hw/edf_formatter.sv ***
// Purpose: Event data formatter; reads processing buffer, writes 36-bit tagged words
// Assumes: Buffer read data valid one clock after the address; one clock domain
// Notes: A 32-word FIFO decouples word assembly from the external FIFO
`include "edf_defines.svh"

module edf_fifo
  import edf_pkg::*;
#(
  parameter int W = `EDF_WORD_W,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_r, rd_ptr_r;
  wire logic full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  wire logic empty = (wr_ptr_r == rd_ptr_r);
  wire logic do_wr = in_valid && !full;
  wire logic do_rd = out_ready && !empty;

  // Handshake flags straight from pointers, head word from the array flops
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_r[PW-1:0]];

  // Storage has no reset; only the pointers define content
  always_ff @(posedge core_clk) begin
    if (do_wr) mem[wr_ptr_r[PW-1:0]] <= in_data;
  end

  // Extra pointer bit tells full from empty
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (PW+1)'(do_wr);
      rd_ptr_r <= rd_ptr_r + (PW+1)'(do_rd);
    end
  end
endmodule // edf_fifo

module edf_formatter
  import edf_pkg::*;
#(
  parameter int NCH = 8,
  parameter int AW = 12,
  parameter int CW = 8,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] mode,
  input wire logic [11:0] window_width,
  input wire logic [NCH-1:0][CW-1:0] pending_block_count,
  input wire logic [NCH-1:0][AW-1:0] start_addr,
  input wire logic [NCH-1:0][AW-1:0] last_addr,
  output logic addr_pop,
  output logic pending_dec,
  output logic fifo_clk_run,
  output logic [AW-1:0] proc_buffer_addr,
  input wire logic [NCH-1:0][`EDF_DATA_W-1:0] proc_buffer_rdata,
  output logic ext_fifo_wr,
  output edf_word_t ext_fifo_wdata,
  input wire logic ext_fifo_full
);
  localparam int CHW = $clog2(NCH);
  edf_main_t state_r, state_nxt;
  edf_s0_t s0_r, s0_nxt;
  edf_s1_t s1_r, s1_nxt;
  edf_s2_t s2_r, s2_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [AW-1:0] start_r [NCH], last_r [NCH];
  logic fresh_r, pair_hi_r, tail_r, run_r;
  logic [2:0] loc_r;
  logic [CHW-1:0] ch_r;
  logic [1:0] mode_r, pn_r, extra_r;
  logic [11:0] width_r;
  logic [15:0] hold_r;
  logic [NCH-1:0] gt1_w;
  logic push_ready, fifo_out_valid;
  edf_word_t fifo_out_data;

  // Pending block counts compared per channel
  for (genvar g = 0; g < NCH; g++) begin : g_pend
    assign gt1_w[g] = pending_block_count[g] > CW'(`EDF_MIN_PENDING);
  end
  wire logic all_ready = &gt1_w;

  // Read data of the channel being formatted
  wire logic [`EDF_DATA_W-1:0] rd_w = proc_buffer_rdata[ch_r];
  wire logic [3:0] chan_w = 4'(ch_r);
  wire logic last_ch = (ch_r == CHW'(NCH-1));
  wire logic at_last = (addr_r == last_r[ch_r]);
  wire logic no_cross = (rd_w[`EDF_HALF_MSB:0] == `EDF_NO_CROSS);
  wire logic is_pulse = (rd_w[`EDF_MARK_MSB:`EDF_MARK_LSB] == `EDF_PULSE_MARK);
  wire logic pair_act = (s0_r == S0_PAIR) || (s1_r == S1_PAIR);

  // Words assembled from buffer data; time stamp passes through untouched
  wire edf_word_t w_hdr = {`EDF_TAG_HDR, 1'b1, `EDF_TYPE_HDR,
                           hold_r[`EDF_TNUM_MSB:0], rd_w[`EDF_HALF_MSB:0]};
  wire edf_word_t w_ts1 = {`EDF_TAG_NONE, 1'b1, `EDF_TYPE_TS, 3'h0,
                           hold_r[`EDF_BYTE_MSB:0], rd_w[`EDF_HALF_MSB:0]};
  wire edf_word_t w_ts2 = {`EDF_TAG_NONE, 8'h00,
                           hold_r[`EDF_BYTE_MSB:0], rd_w[`EDF_HALF_MSB:0]};
  wire edf_word_t w_win = {`EDF_TAG_NONE, 1'b1, `EDF_TYPE_WIN, chan_w, 11'h000,
                           width_r};
  wire edf_word_t w_praw = {`EDF_TAG_NONE, 1'b1, `EDF_TYPE_PRAW, chan_w,
                            rd_w[`EDF_PN_MSB:`EDF_PN_LSB], 11'h000,
                            rd_w[`EDF_TIME_MSB:0]};
  wire edf_word_t w_pair = {`EDF_TAG_NONE, 2'h0, hold_r[`EDF_INV_BIT],
                            hold_r[`EDF_SMP_MSB:0], 2'h0, rd_w[`EDF_INV_BIT],
                            rd_w[`EDF_SMP_MSB:0]};
  wire edf_word_t w_ptime = {`EDF_TAG_NONE, 1'b1, `EDF_TYPE_PTIME, chan_w,
                             rd_w[`EDF_PN_MSB:`EDF_PN_LSB], `EDF_QUALITY, 3'h0, 6'h00,
                             rd_w[`EDF_TIME_MSB:0]};
  wire edf_word_t w_pint = {`EDF_TAG_NONE, 1'b1, `EDF_TYPE_PINT, chan_w, pn_r,
                            `EDF_QUALITY, hold_r, rd_w[`EDF_SUMLO_MSB:0]};
  wire edf_word_t w_trl = `EDF_TRAILER;

  // Push requests; every word waits for a fresh buffer read where it needs one
  wire logic p_hdr = (state_r == M_HDR) && fresh_r && loc_r[0];
  wire logic p_trl = (state_r == M_TRAIL);
  wire logic p_win = (s0_r == S0_WIN);
  wire logic p_praw = (s1_r == S1_PULSE) && fresh_r;
  wire logic p_pair = pair_act && fresh_r && pair_hi_r;
  wire logic p_ptime = (s2_r == S2_TIME) && fresh_r && is_pulse;
  wire logic p_pint = (s2_r == S2_SUMLO) && fresh_r;
  wire logic push_valid = p_hdr | p_trl | p_win | p_praw | p_pair | p_ptime | p_pint;
  wire edf_word_t hdr_word = (loc_r == 3'h1) ? w_hdr : (loc_r == 3'h3) ? w_ts1 : w_ts2;
  wire edf_word_t push_data = p_hdr ? hdr_word : p_trl ? w_trl : p_win ? w_win :
                              p_praw ? w_praw : p_pair ? w_pair :
                              p_ptime ? w_ptime : w_pint;

  // Consumption of a buffer word; stalls ride on push_ready
  wire logic hdr_take = (state_r == M_HDR) && fresh_r && (!loc_r[0] || push_ready);
  wire logic win_take = p_win && push_ready;
  wire logic praw_take = p_praw && push_ready;
  wire logic pair_take = pair_act && fresh_r && (!pair_hi_r || push_ready);
  wire logic ptime_take = p_ptime && push_ready;
  wire logic sumhi_take = (s2_r == S2_SUMHI) && fresh_r;
  wire logic pint_take = p_pint && push_ready;
  wire logic pair_done = pair_take && tail_r && (extra_r == `EDF_EXTRA_ODD);
  wire logic hdr_end = hdr_take && (loc_r == `EDF_LOC_TS2);
  wire logic chk_go = (state_r == M_CHK) && fresh_r && !no_cross;
  wire logic chk_skip = (state_r == M_CHK) && fresh_r && no_cross;
  wire logic next_load = (state_r == M_NEXT) && !last_ch;
  wire logic step = (hdr_take && !hdr_end) | win_take | praw_take | pair_take |
                    ptime_take | sumhi_take | pint_take;
  wire logic sub_done = (s0_r == S0_DONE) || (s1_r == S1_DONE) || (s2_r == S2_DONE);
  wire logic [CHW-1:0] ch_sel = next_load ? ch_r + CHW'(1) : ch_r;
  wire logic [AW-1:0] halt_off = (mode_r == 2'h0) ? AW'(`EDF_LOC_WIN) : AW'(`EDF_LOC_DATA);

  // Address counter: loads on pop, channel peek and halt point, else steps
  always_comb begin
    addr_nxt = addr_r;
    if (state_r == M_POP) addr_nxt = start_addr[0];
    else if (hdr_end || next_load) addr_nxt = start_r[ch_sel] + AW'(`EDF_LOC_DATA);
    else if (chk_go) addr_nxt = start_r[ch_r] + halt_off;
    else if (step) addr_nxt = addr_r + AW'(1);
  end

  // Main sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      M_IDLE: if (all_ready) state_nxt = M_POP;
      M_POP: state_nxt = M_HDR;
      M_HDR: if (hdr_end) state_nxt = M_CHK;
      M_CHK: begin
        if (chk_skip) state_nxt = M_NEXT;
        else if (chk_go) state_nxt = M_CALL;
      end
      M_CALL: if (sub_done) state_nxt = M_NEXT;
      M_NEXT: state_nxt = last_ch ? M_TRAIL : M_CHK;
      M_TRAIL: if (push_ready) state_nxt = M_DONE;
      M_DONE: state_nxt = M_IDLE;
    endcase
  end

  // Mode 0 machine: generated window word, then sample pairs
  always_comb begin
    s0_nxt = s0_r;
    unique case (s0_r)
      S0_IDLE: if (state_r == M_CALL && mode_r == 2'h0) s0_nxt = S0_WIN;
      S0_WIN: if (win_take) s0_nxt = S0_PAIR;
      S0_PAIR: if (pair_done) s0_nxt = S0_DONE;
      S0_DONE: s0_nxt = S0_IDLE;
    endcase
  end
  // Mode 1 machine: pulse raw word, then sample pairs
  always_comb begin
    s1_nxt = s1_r;
    unique case (s1_r)
      S1_IDLE: if (state_r == M_CALL && mode_r == 2'h1) s1_nxt = S1_PULSE;
      S1_PULSE: if (praw_take) s1_nxt = S1_PAIR;
      S1_PAIR: if (pair_done) s1_nxt = S1_DONE;
      S1_DONE: s1_nxt = S1_IDLE;
    endcase
  end
  // Mode 2 machine: pulse time and integral per pulse, leftovers never pushed
  always_comb begin
    s2_nxt = s2_r;
    unique case (s2_r)
      S2_IDLE: if (state_r == M_CALL && mode_r == 2'h2) s2_nxt = S2_TIME;
      S2_TIME: begin
        if (fresh_r && !is_pulse) s2_nxt = S2_DONE;
        else if (ptime_take) s2_nxt = S2_SUMHI;
      end
      S2_SUMHI: if (sumhi_take) s2_nxt = S2_SUMLO;
      S2_SUMLO: if (pint_take) s2_nxt = at_last ? S2_DONE : S2_TIME;
      default: s2_nxt = S2_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= M_IDLE;
      s0_r <= S0_IDLE;
      s1_r <= S1_IDLE;
      s2_r <= S2_IDLE;
    end else begin
      state_r <= state_nxt;
      s0_r <= s0_nxt;
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  // Address and read freshness; data is valid one clock after any address change
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r <= '0;
      fresh_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      fresh_r <= (addr_nxt == addr_r) && (state_r != M_POP) && !hdr_end && !next_load
                 && !chk_go && !step;
    end
  end

  // Event context captured when the addresses are popped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= 2'h0;
      width_r <= 12'h000;
      run_r <= 1'b0;
      loc_r <= 3'h0;
      ch_r <= '0;
    end else begin
      if (state_r == M_POP) begin
        mode_r <= mode;
        width_r <= window_width;
      end
      if (state_r == M_POP) run_r <= 1'b1;
      else if (state_r == M_DONE) run_r <= 1'b0;
      if (state_r == M_POP) loc_r <= 3'h0;
      else if (hdr_take) loc_r <= loc_r + 3'h1;
      if (state_r == M_POP) ch_r <= '0;
      else if (next_load) ch_r <= ch_sel;
    end
  end

  // Address table; no reset needed, written before any use
  always_ff @(posedge core_clk) begin
    if (state_r == M_POP) begin
      for (int i = 0; i < NCH; i++) begin
        start_r[i] <= start_addr[i];
        last_r[i] <= last_addr[i];
      end
    end
  end
  // Held half-words and pulse number
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r <= 16'h0000;
      pn_r <= 2'h0;
    end else begin
      if ((hdr_take && !loc_r[0]) || (pair_take && !pair_hi_r) || sumhi_take)
        hold_r <= rd_w[`EDF_HALF_MSB:0];
      if (ptime_take) pn_r <= rd_w[`EDF_PN_MSB:`EDF_PN_LSB];
    end
  end

  // Tail count: past the last address one more sample if odd, two if even
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_hi_r <= 1'b0;
      tail_r <= 1'b0;
      extra_r <= 2'h0;
    end else if (state_r == M_CHK) begin
      pair_hi_r <= 1'b0;
      tail_r <= 1'b0;
    end else if (pair_take) begin
      pair_hi_r <= !pair_hi_r;
      if (!tail_r && at_last) begin
        tail_r <= 1'b1;
        extra_r <= pair_hi_r ? `EDF_EXTRA_EVEN : `EDF_EXTRA_ODD;
      end else if (tail_r) begin
        extra_r <= extra_r - 2'h1;
      end
    end
  end
  // Word buffer between assembly and the external FIFO
  edf_fifo #(.W(`EDF_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(!ext_fifo_full),
    .out_data(fifo_out_data)
  );
  // Outputs; a full external FIFO simply holds the head word in place
  assign ext_fifo_wr = fifo_out_valid && !ext_fifo_full;
  assign ext_fifo_wdata = fifo_out_data;
  assign addr_pop = (state_r == M_POP);
  assign pending_dec = (state_r == M_DONE);
  assign fifo_clk_run = run_r;
  assign proc_buffer_addr = addr_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence pop_seq;
    addr_pop ##1 (state_r == M_HDR && fifo_clk_run && proc_buffer_addr == start_r[0]);
  endsequence
  sequence trailer_seq;
    push_valid && push_ready && p_trl ##1 pending_dec ##1 !fifo_clk_run;
  endsequence
  start_gate_a: assert property ($rose(addr_pop) |-> $past(all_ready))
    else $error("write-out began without all pending counts above one");
  pop_load_a: assert property (addr_pop |-> pop_seq)
    else $error("pop did not load channel 0 start and run the clock");
  no_full_wr_a: assert property (ext_fifo_wr |-> !ext_fifo_full)
    else $error("write strobe while external FIFO full");
  held_word_a: assert property (ext_fifo_full && fifo_out_valid |=>
                                $stable(ext_fifo_wdata))
    else $error("head word changed while stalled");
  trailer_val_a: assert property (push_valid && p_trl |-> push_data == `EDF_TRAILER)
    else $error("trailer word wrong");
  trailer_end_a: assert property (p_trl && push_ready |-> trailer_seq)
    else $error("trailer not followed by count decrement and clock stop");
  header_fmt_a: assert property (p_hdr && loc_r == 3'h1 |->
                                 push_data[35:27] == 9'h032)
    else $error("event header tag or type wrong");
  win_halt_a: assert property (s0_r == S0_WIN |->
                               addr_r == start_r[ch_r] + AW'(`EDF_LOC_WIN))
    else $error("mode 0 address not halted at 5");
  pulse_halt_a: assert property ((s1_r == S1_PULSE || s2_r == S2_TIME) && $rose(fresh_r)
                                 && $past(s1_r) == S1_IDLE && $past(s2_r) == S2_IDLE |->
                                 addr_r == start_r[ch_r] + AW'(`EDF_LOC_DATA))
    else $error("pulse modes not halted at 6");
  skip_chan_a: assert property (chk_skip |=> state_r == M_NEXT ##1
                                s0_r == S0_IDLE && s1_r == S1_IDLE)
    else $error("suppressed channel was not skipped");
  leftover_a: assert property (s2_r == S2_TIME && fresh_r && !is_pulse |-> !push_valid
                               ##1 s2_r == S2_DONE)
    else $error("mode 2 leftover word pushed");
endmodule // edf_formatter

// *** hw/edf_defines.svh ***
// Purpose: Constants for the event data formatter: word tags, types, field positions
// Assumes: Included by the formatter design file
// Notes: Positions refer to 18-bit processing-buffer words or 36-bit output words
`ifndef EDF_DEFINES_SVH
`define EDF_DEFINES_SVH
`define EDF_WORD_W 36
`define EDF_DATA_W 18
`define EDF_TAG_HDR 4'h1
`define EDF_TAG_NONE 4'h0
`define EDF_TYPE_HDR 4'h2
`define EDF_TYPE_TS 4'h3
`define EDF_TYPE_WIN 4'h4
`define EDF_TYPE_PRAW 4'h6
`define EDF_TYPE_PINT 4'h7
`define EDF_TYPE_PTIME 4'h8
`define EDF_TRAILER 36'h2E8000000
`define EDF_NO_CROSS 16'hFFF0
`define EDF_PULSE_MARK 2'h2
`define EDF_QUALITY 2'h0
`define EDF_LOC_TS2 3'h5
`define EDF_LOC_WIN 4'h5
`define EDF_LOC_DATA 4'h6
`define EDF_MIN_PENDING 1
`define EDF_EXTRA_ODD 2'h1
`define EDF_EXTRA_EVEN 2'h2
`define EDF_HALF_MSB 15
`define EDF_MARK_MSB 17
`define EDF_MARK_LSB 16
`define EDF_INV_BIT 13
`define EDF_SMP_MSB 12
`define EDF_PN_MSB 11
`define EDF_PN_LSB 10
`define EDF_TNUM_MSB 10
`define EDF_TIME_MSB 9
`define EDF_BYTE_MSB 7
`define EDF_SUMLO_MSB 2
`endif

// *** hw/edf_pkg.sv ***
// Purpose: Types shared by the event data formatter
// Assumes: Constants come from edf_defines.svh
// Notes: Output word carried as a packed struct of tag nibble and 32-bit body
package edf_pkg;
  typedef struct packed {
    logic [3:0] tag;
    logic [31:0] body;
  } edf_word_t;
  typedef enum logic [2:0] {
    M_IDLE, M_POP, M_HDR, M_CHK, M_CALL, M_NEXT, M_TRAIL, M_DONE
  } edf_main_t;
  typedef enum logic [1:0] {S0_IDLE, S0_WIN, S0_PAIR, S0_DONE} edf_s0_t;
  typedef enum logic [1:0] {S1_IDLE, S1_PULSE, S1_PAIR, S1_DONE} edf_s1_t;
  typedef enum logic [2:0] {S2_IDLE, S2_TIME, S2_SUMHI, S2_SUMLO, S2_DONE} edf_s2_t;
endpackage

// *** dv/edf_ext_fifo_model.sv ***
// Purpose: Far-side FIFO model; records every word taken, stalls on request
// Assumes: A write is taken on a rising edge while full is low
// Notes: Random stalls come from a fixed seed, so runs repeat exactly
module edf_ext_fifo_model
  import edf_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wr,
  input wire edf_word_t wdata,
  input wire logic stall_en,
  input wire logic hold_full,
  output logic full
);
  timeunit 1ns;
  timeprecision 1ns;
  edf_word_t got[$];
  int n_bad = 0;
  int seed = 32'h1DE2;
  initial full = 1'b0;
  // Strobe while full would be a lost word, so it is counted, not stored
  always @(posedge core_clk) begin
    if (wr && full) begin
      n_bad++;
    end else if (wr && !sys_rst) begin
      got.push_back(wdata);
    end
    full <= hold_full || (stall_en && (($random(seed) & 3) == 0));
  end
endmodule // edf_ext_fifo_model

// *** dv/event_data_formatter_test.sv ***
// Purpose: Self-checking bench for the event formatter, all three modes
// Assumes: Buffer data follows the address at once, well inside one clock
// Notes: Every channel shares one start address; channel 5 carries no crossing
module event_data_formatter_test
  import edf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ST = 16;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [11:0] width = 12'h000;
  logic [7:0][7:0] cnt = '0;
  logic [7:0][11:0] sa = {8{12'h010}};
  logic [7:0][11:0] la = {8{12'h018}};
  logic [7:0][17:0] rdata;
  logic [11:0] addr;
  logic addr_pop, pending_dec, clk_run, wr, full;
  logic stall_en = 1'b0;
  logic hold_full = 1'b0;
  edf_word_t wdata;
  logic [17:0] mem [8][256];
  logic [35:0] exp_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 32'h1DE2;

  always #25 core_clk = ~core_clk;
  // Buffer answers from its array; shared address, one lane per channel
  always @* for (int c = 0; c < 8; c++) rdata[c] = mem[c][addr[7:0]];
  // Far side lowers every count once per block read
  always @(posedge core_clk) begin
    if (pending_dec) begin
      for (int c = 0; c < 8; c++) cnt[c] <= cnt[c] - 8'h01;
    end
  end

  edf_formatter edf_formatter_i (.core_clk(core_clk), .sys_rst(sys_rst), .mode(mode),
    .window_width(width), .pending_block_count(cnt), .start_addr(sa), .last_addr(la),
    .addr_pop(addr_pop), .pending_dec(pending_dec), .fifo_clk_run(clk_run),
    .proc_buffer_addr(addr), .proc_buffer_rdata(rdata), .ext_fifo_wr(wr),
    .ext_fifo_wdata(wdata), .ext_fifo_full(full));
  edf_ext_fifo_model edf_ext_fifo_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .wr(wr),
    .wdata(wdata), .stall_en(stall_en), .hold_full(hold_full), .full(full));

  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [35:0] g, input logic [35:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bounded wait: 0 pop, 1 end of event, 2 all expected words taken
  task wait_until(input int which, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(negedge core_clk);
      if ((which == 0 && addr_pop === 1'b1) || (which == 1 && pending_dec === 1'b1) ||
          (which == 2 && edf_ext_fifo_model_i.got.size() == exp_q.size())) break;
    end
    if (i == bound) begin
      n_fail++;
      $display("[FAIL] t=%0t wait %h got=%h exp=%h", $time, which, 0, 1);
      print_verdict();
    end
  endtask

  function automatic logic [35:0] hw(int ch, logic [1:0] pn, logic [3:0] ty, logic [20:0] lo);
    return {4'h0, 1'b1, ty, 4'(ch), pn, lo};
  endfunction

  // Reference stream worked out from the buffer contents
  task build(input int md);
    int p, n, e, a;
    exp_q = {};
    exp_q.push_back({4'h1, 1'b1, 4'h2, mem[0][ST][10:0], mem[0][ST+1][15:0]});
    exp_q.push_back({4'h0, 1'b1, 4'h3, 3'h0, mem[0][ST+2][7:0], mem[0][ST+3][15:0]});
    exp_q.push_back({4'h0, 8'h00, mem[0][ST+4][7:0], mem[0][ST+5][15:0]});
    for (int c = 0; c < 8; c++) begin
      p = ST + 6;
      if (mem[c][p][15:0] == 16'hFFF0) continue;
      if (md == 0) exp_q.push_back(hw(c, 2'h0, 4'h4, {9'h000, width}));
      if (md == 1) begin
        exp_q.push_back(hw(c, mem[c][p][11:10], 4'h6, {11'h000, mem[c][p][9:0]}));
        p++;
      end
      if (md < 2) begin
        n = la[c] - p + 1;
        e = la[c] + ((n % 2 == 1) ? 1 : 2);
        for (a = p; a < e; a += 2)
          exp_q.push_back({6'h00, mem[c][a][13:0], 2'b00, mem[c][a+1][13:0]});
      end else begin
        a = p;
        while (mem[c][a][17:16] == 2'b10 && a + 2 <= la[c]) begin
          exp_q.push_back(hw(c, mem[c][a][11:10], 4'h8, {11'h000, mem[c][a][9:0]}));
          exp_q.push_back(hw(c, mem[c][a][11:10], 4'h7,
            {2'b00, mem[c][a+1][15:0], mem[c][a+2][2:0]}));
          a += 3;
        end
      end
    end
    exp_q.push_back(36'h2E8000000);
  endtask

  // One whole event: fill buffer, release counts, check the stream taken
  task run_event(input int md, input logic st, input logic hold);
    @(posedge core_clk);
    for (int c = 0; c < 8; c++) begin
      for (int a = 0; a < 256; a++) mem[c][a] = {2'b00, 16'($random(seed))};
      mem[c][ST+6][17:16] = 2'b10;
      mem[c][ST+9][17:16] = 2'b10;
      mem[c][ST+12][17:16] = 2'b11;
      mem[c][ST+13][17:16] = 2'b10;
      la[c] <= (md == 2) ? 12'(ST + 14) : 12'(ST + 8 + c);
      cnt[c] <= 8'h02;
    end
    mem[5][ST+6] = 18'h0FFF0;
    width <= 12'($random(seed));
    mode <= 2'(md);
    stall_en <= st;
    @(posedge core_clk);
    build(md);
    wait_until(0, 50);
    @(posedge core_clk);
    #1;
    chk({24'h000000, addr}, 36'(ST));
    chk({35'h0, clk_run}, 36'h1);
    if (hold) begin
      hold_full <= 1'b1;
      repeat (300) @(posedge core_clk);
      chk(36'(edf_ext_fifo_model_i.got.size()), 36'h0);
      hold_full <= 1'b0;
    end
    wait_until(1, 5000);
    wait_until(2, 3000);
    repeat (30) begin
      @(negedge core_clk);
      chk({35'h0, addr_pop}, 36'h0);
      chk({35'h0, clk_run}, 36'h0);
    end
    chk(36'(edf_ext_fifo_model_i.got.size()), 36'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < edf_ext_fifo_model_i.got.size(); i++)
      chk(edf_ext_fifo_model_i.got[i], exp_q[i]);
    chk(36'(edf_ext_fifo_model_i.n_bad), 36'h0);
    edf_ext_fifo_model_i.got.delete();
    $display("event in mode %0d stall %0d hold %0d done", md, st, hold);
  endtask

  // Reset, refusal with one count at the boundary, then events in every mode
  initial begin
    for (int c = 0; c < 8; c++) for (int a = 0; a < 256; a++) mem[c][a] = 18'h00000;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int c = 0; c < 8; c++) cnt[c] <= (c == 3) ? 8'h01 : 8'h05;
    repeat (40) begin
      @(negedge core_clk);
      chk({35'h0, addr_pop}, 36'h0);
    end
    $display("start refused while one count is one");
    run_event(0, 1'b0, 1'b0);
    run_event(1, 1'b1, 1'b0);
    run_event(2, 1'b1, 1'b0);
    run_event(0, 1'b1, 1'b1);
    run_event(1, 1'b0, 1'b1);
    print_verdict();
  end
endmodule // event_data_formatter_test
